// ===== core/its_timer_status.v
// Three 16-bit interval timers, cascade option, sticky event status, AHB-Lite slave
// Assumes one 250 MHz clock; all inputs synchronous to it apart from the
// external timer clocks and error pins, which are resynchronised here.
// Register words sit at four times their index on the bus.
// Timer outputs idle high and drop low for the last count.
//
// Function
// [RULE1] Parity error assertion sets status bit 4
// [RULE2] System error assertion sets status bit 3
// [RULE3] Timer output rising edges set bits 2..0
// [RULE4] Writing one clears bit, zero no effect
// [RULE5] Timer status stays set until cleared
// [RULE6] Status latches regardless of mask settings
// [RULE7] Software writes zero to reserved bits
// [RULE8] Control bits 7..5 drive timer gates
// [RULE9] Control bit 4 zero cascades timers 1,2
// [RULE10] Control bit 3 picks timer 1 clock
// [RULE11] Control bit 2 picks timer 0 clock
// [RULE12] Internal timer clock is clock divided eight
// [RULE13] Three binary 16-bit timers, decimal bit ignored
// [RULE14] Cascade: timer 1 output clocks timer 2
// [RULE15] Timer 2 uses internal clock unless cascaded
// [RULE16] Cascade low timer full range is advisory
// [RULE17] Mask bit gates each source onto interrupt
// [RULE18] Global enable bit gates interrupt output
// [RULE19] Reset clears status and control bits
// [RULE20] External and error inputs synchronised first
`timescale 1ns/1ps
`include "its_map.vh"

module its_timer_status #(
    parameter TMR_W = 16
) (
    // Clock and reset
    input  wire        clk_in,
    input  wire        resetn_in,

    // AHB-Lite slave
    input  wire        hsel_in,
    input  wire [31:0] haddr_in,
    input  wire [1:0]  htrans_in,
    input  wire        hwrite_in,
    input  wire [2:0]  hsize_in,
    input  wire [31:0] hwdata_in,
    input  wire        hready_in,
    output reg  [31:0] hrdata_out,
    output reg         hreadyout_out,
    output reg         hresp_out,

    // External timer clocks and bus error pins
    input  wire        ext_clock_in_0_in,
    input  wire        ext_clock_in_1_in,
    input  wire        perr_n_in,
    input  wire        serr_n_in,

    // Timer outputs and interrupt
    output reg  [2:0]  timer_out,
    output reg         irq_out
);

    // Reset release synchroniser
    // Assert at once, release retimed through two flops
    // Everything below resets from the retimed copy
    reg [1:0] rst_sync_reg;
    wire      rst_n;

    always @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in)
            rst_sync_reg <= 2'b00;
        else
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
    // Retimed reset for all other registers
    assign rst_n = rst_sync_reg[1];

    // Event status and its next value
    // Reserved upper bits are not stored, so read as zero
    reg [`ITS_EVT_W-1:0] status_reg;
    reg [`ITS_EVT_W-1:0] status_next;

    // Control registers
    reg [`ITS_EVT_W-1:0] mask_reg;
    reg [7:0]            irq_ctrl_reg;
    reg [7:0]            tctrl_reg;
    reg [7:0]            tmode_reg;

    // Reload values and counter restart strobes
    reg [3*TMR_W-1:0]    reload_reg;
    reg [2:0]            load_pulse_reg;

    // Address phase capture
    // Index of a write waiting for its data phase
    reg        wr_pend_reg;
    reg [9:0]  wr_idx_reg;
    wire       take;
    wire [9:0] idx;

    // A transfer is taken when selected, active and ready
    assign take = hsel_in & htrans_in[1] & hready_in;
    assign idx  = haddr_in[11:2];

    // Input synchronisers: ext0, ext1, perr, serr
    // Error pins inverted here: a one means the pin was low
    // Only the second stage is read; the first may be metastable
    reg [3:0] sync1_reg;
    reg [3:0] sync2_reg;
    reg [1:0] ext_d_reg;
    wire [3:0] in_raw;

    // Raw pins, active high
    assign in_raw = {~serr_n_in, ~perr_n_in, ext_clock_in_1_in, ext_clock_in_0_in};

    always @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            sync1_reg <= 4'h0;
            sync2_reg <= 4'h0;
            ext_d_reg <= 2'b00;
        end else begin
            sync1_reg <= in_raw;            // RULE20
            sync2_reg <= sync1_reg;
            ext_d_reg <= sync2_reg[1:0];
        end
    end

    // Rising edges of the synchronised external clocks
    wire [1:0] ext_rise;
    assign ext_rise = sync2_reg[1:0] & ~ext_d_reg; // RULE20

    // Internal timer clock enable, one pulse every eighth cycle
    // Registered tick, one cycle after the count reaches seven
    // Period stays exactly eight, so timing is unaffected
    reg [`ITS_DIV_W-1:0] div_reg;
    reg                  div_tick_reg;

    always @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            div_reg      <= {`ITS_DIV_W{1'b0}};
            div_tick_reg <= 1'b0;
        end else begin
            div_reg      <= div_reg + 1'b1;  // RULE12
            div_tick_reg <= (div_reg == `ITS_DIV_RATIO - 1);
        end
    end

    // Timer clock enable selection
    // Timer 2 never takes an external clock
    reg  [2:0] out_d_reg;
    wire [2:0] out_rise;
    wire [2:0] tick;
    wire [2:0] gate;
    wire [2:0] step;
    wire [2:0] out_val;

    // Timer output rises, gate and tick per timer
    assign out_rise = timer_out & ~out_d_reg;
    assign gate     = tctrl_reg[`ITS_BIT_GATE0+2:`ITS_BIT_GATE0];          // RULE8
    assign tick[0]  = tctrl_reg[`ITS_BIT_T0SRC] ? div_tick_reg : ext_rise[0]; // RULE11
    assign tick[1]  = tctrl_reg[`ITS_BIT_T1SRC] ? div_tick_reg : ext_rise[1]; // RULE10
    assign tick[2]  = tctrl_reg[`ITS_BIT_CASCADE] ? div_tick_reg           // RULE9 RULE15
                                                  : out_rise[1];            // RULE14

    // Counters: binary down count, reload at one, output low for one count
    wire [3*TMR_W-1:0] cnt_all;

    // Next count: wrap to the reload value at one, else step down
    // Reload value zero wraps through the full range
    function [TMR_W-1:0] its_cnt_next;
        input [TMR_W-1:0] cur;
        input [TMR_W-1:0] rld_val;
        begin
            if (cur == `ITS_CNT_ONE)
                its_cnt_next = rld_val;
            else
                its_cnt_next = cur - 1'b1;
        end
    endfunction

    // One counter per timer
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : tmr
            // Count, its reload value and next value
            reg  [TMR_W-1:0] cnt_reg;
            wire [TMR_W-1:0] rld;
            wire [TMR_W-1:0] cnt_nx;

            assign rld        = reload_reg[g*TMR_W +: TMR_W];
            assign cnt_nx     = its_cnt_next(cnt_reg, rld);
            assign cnt_all[g*TMR_W +: TMR_W] = cnt_reg;

            // Counting tick only while the gate is high
            assign step[g]    = tick[g] & gate[g];                  // RULE8
            // Output falls as the count reaches one
            assign out_val[g] = (cnt_nx != `ITS_CNT_ONE);

            // Binary counting only; decimal mode bit is not consulted
            always @(posedge clk_in or negedge rst_n) begin
                if (!rst_n)
                    cnt_reg <= `ITS_RST_RELOAD;
                else if (load_pulse_reg[g])
                    cnt_reg <= rld;
                else if (step[g])
                    cnt_reg <= cnt_nx;                              // RULE13
            end
        end
    endgenerate

    // Timer outputs in one register, so each bit has one driver
    // A restart forces high; a tick follows the count
    always @(posedge clk_in or negedge rst_n) begin
        if (!rst_n)
            timer_out <= 3'b111;
        else
            timer_out <= load_pulse_reg | (step & out_val) | (~step & timer_out); // RULE13
    end

    // Previous timer outputs for edge detection
    // Reset value matches the idle high outputs, so no false edge
    always @(posedge clk_in or negedge rst_n) begin
        if (!rst_n)
            out_d_reg <= 3'b111;
        else
            out_d_reg <= timer_out;
    end

    // Event sources and write-one-to-clear
    // A new event in the clearing cycle survives the clear
    reg  [`ITS_EVT_W-1:0] clr;
    wire [`ITS_EVT_W-1:0] evt_set;

    // Pending write aimed at one register index
    function its_wr_hit;
        input       pend;
        input [9:0] widx;
        input [9:0] want;
        begin
            its_wr_hit = pend && (widx == want);
        end
    endfunction

    // Error levels and timer output rises
    assign evt_set = {sync2_reg[2],       // RULE1
                      sync2_reg[3],       // RULE2
                      out_rise};          // RULE3

    always @* begin
        clr = {`ITS_EVT_W{1'b0}};
        if (its_wr_hit(wr_pend_reg, wr_idx_reg, `ITS_IDX_STATUS))
            clr = hwdata_in[`ITS_EVT_W-1:0];                  // RULE4
        // Set wins over clear; mask not involved
        status_next = (status_reg & ~clr) | evt_set;          // RULE5 RULE6
    end

    // Register writes in the data phase
    // hwdata stands in the cycle after the captured address phase
    // Reload writes also restart the matching counter
    always @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            status_reg     <= `ITS_RST_STATUS;               // RULE19
            tctrl_reg      <= `ITS_RST_TCTRL;                // RULE19
            mask_reg       <= `ITS_RST_MASK;
            irq_ctrl_reg   <= `ITS_RST_IRQ_CTRL;
            tmode_reg      <= 8'h00;
            reload_reg     <= {3{`ITS_RST_RELOAD}};
            load_pulse_reg <= 3'b000;
        end else begin
            status_reg     <= status_next;
            load_pulse_reg <= 3'b000;
            if (wr_pend_reg) begin
                case (wr_idx_reg)
                    `ITS_IDX_TCTRL:    tctrl_reg    <= hwdata_in[7:0];
                    `ITS_IDX_MASK:     mask_reg     <= hwdata_in[`ITS_EVT_W-1:0];
                    `ITS_IDX_IRQ_CTRL: irq_ctrl_reg <= hwdata_in[7:0];
                    `ITS_IDX_TMODE:    tmode_reg    <= hwdata_in[7:0]; // RULE13
                    `ITS_IDX_RELOAD0: begin
                        reload_reg[0*TMR_W +: TMR_W] <= hwdata_in[TMR_W-1:0];
                        load_pulse_reg[0]            <= 1'b1;
                    end
                    `ITS_IDX_RELOAD1: begin
                        reload_reg[1*TMR_W +: TMR_W] <= hwdata_in[TMR_W-1:0];
                        load_pulse_reg[1]            <= 1'b1;
                    end
                    `ITS_IDX_RELOAD2: begin
                        reload_reg[2*TMR_W +: TMR_W] <= hwdata_in[TMR_W-1:0];
                        load_pulse_reg[2]            <= 1'b1;
                    end
                    default: ;
                endcase
            end
        end
    end

    // Read mux
    // Selected from the address phase, so data leaves with no wait state
    // Reload indices read the running count, not the reload value
    reg [31:0] rd_mux;

    always @* begin
        rd_mux = 32'h0000_0000;
        case (idx)
            `ITS_IDX_STATUS:   rd_mux[`ITS_EVT_W-1:0] = status_reg;   // RULE1 RULE2
            `ITS_IDX_MASK:     rd_mux[`ITS_EVT_W-1:0] = mask_reg;
            `ITS_IDX_IRQ_CTRL: rd_mux[7:0]            = irq_ctrl_reg;
            `ITS_IDX_TCTRL:    rd_mux[7:0]            = tctrl_reg;
            `ITS_IDX_TMODE:    rd_mux[7:0]            = tmode_reg;
            `ITS_IDX_RELOAD0:  rd_mux[TMR_W-1:0]      = cnt_all[0*TMR_W +: TMR_W];
            `ITS_IDX_RELOAD1:  rd_mux[TMR_W-1:0]      = cnt_all[1*TMR_W +: TMR_W];
            `ITS_IDX_RELOAD2:  rd_mux[TMR_W-1:0]      = cnt_all[2*TMR_W +: TMR_W];
            default:           rd_mux                 = 32'h0000_0000;
        endcase
    end

    // Bus slave: zero wait states, always OKAY
    // Size is not checked; every register is one whole word
    // Unmapped indices read zero and ignore writes
    always @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            wr_pend_reg   <= 1'b0;
            wr_idx_reg    <= 10'h000;
            hrdata_out    <= 32'h0000_0000;
            hreadyout_out <= 1'b1;
            hresp_out     <= 1'b0;
        end else begin
            hreadyout_out <= 1'b1;
            hresp_out     <= 1'b0;
            if (hready_in) begin
                wr_pend_reg <= take & hwrite_in;
                wr_idx_reg  <= idx;
                if (take & ~hwrite_in)
                    hrdata_out <= rd_mux;
            end
        end
    end

    // Interrupt output
    // Uses the next status, so it rises with the status bit itself
    // Mask and global enable gate only this pin, never the status
    always @(posedge clk_in or negedge rst_n) begin
        if (!rst_n)
            irq_out <= 1'b0;
        else
            irq_out <= irq_ctrl_reg[`ITS_BIT_GIE] &           // RULE18
                       (|(status_next & mask_reg));            // RULE17
    end

endmodule

// ===== core/its_map.vh
// Register map and constants of the interval timer and event status block
// Assumes a 32-bit AHB-Lite bus; register byte address is four times its index
`ifndef ITS_MAP_VH
`define ITS_MAP_VH

// Register indices (byte address = index * 4)
`define ITS_IDX_IRQ_CTRL   10'h1e3
`define ITS_IDX_MASK       10'h1e4
`define ITS_IDX_STATUS     10'h1e5
`define ITS_IDX_TCTRL      10'h1e6
`define ITS_IDX_RELOAD0    10'h1f0
`define ITS_IDX_RELOAD1    10'h1f1
`define ITS_IDX_RELOAD2    10'h1f2
`define ITS_IDX_TMODE      10'h1f3

// Event status and mask bit positions
`define ITS_BIT_PERR       4
`define ITS_BIT_SERR       3
`define ITS_BIT_TC2        2
`define ITS_BIT_TC1        1
`define ITS_BIT_TC0        0
`define ITS_EVT_W          5

// Interrupt control register
`define ITS_BIT_GIE        4

// Timer control register bit positions
`define ITS_BIT_GATE0      5
`define ITS_BIT_CASCADE    4
`define ITS_BIT_T1SRC      3
`define ITS_BIT_T0SRC      2

// Timer mode register: binary/decimal bit, stored only
`define ITS_BIT_BCD        0

// Reset values
`define ITS_RST_STATUS     5'h00
`define ITS_RST_TCTRL      8'h00
`define ITS_RST_MASK       5'h00
`define ITS_RST_IRQ_CTRL   8'h00
`define ITS_RST_RELOAD     16'h0000

// Internal timer clock divider
`define ITS_DIV_RATIO      8
`define ITS_DIV_W          3

// Counter terminal values
`define ITS_CNT_ONE        16'h0001

`endif

// ===== testbench/its_timer_status_sva.sv
// Port assertions for the timer and event status block
// Assumes the master makes single word transfers, never pipelined
`timescale 1ns/1ps
`include "its_map.vh"
module its_timer_status_sva (
    input wire        clk_in,
    input wire        resetn_in,
    input wire        hsel_in,
    input wire [31:0] haddr_in,
    input wire [1:0]  htrans_in,
    input wire        hwrite_in,
    input wire [31:0] hwdata_in,
    input wire        hready_in,
    input wire [31:0] hrdata_out,
    input wire        hreadyout_out,
    input wire        hresp_out,
    input wire [2:0]  timer_out,
    input wire        irq_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!resetn_in);
    // Transfer decode
    wire       tk = hsel_in & htrans_in[1] & hready_in;
    wire [9:0] ix = haddr_in[11:2];
    wire       rd = tk & !hwrite_in;
    wire       mp = (ix >= 10'h1e3 && ix <= 10'h1e6) || (ix >= 10'h1f0 && ix <= 10'h1f3);
    a_ready_high: assert property (hreadyout_out) else $error("wait state inserted");
    a_resp_okay: assert property (!hresp_out) else $error("error response");
    a_reset_idle: assert property ($rose(resetn_in) |-> timer_out == 3'h7 && !irq_out && hrdata_out == 32'h0)
        else $error("outputs not idle at reset release");
    a_unmapped_zero: assert property (rd && !mp |=> hrdata_out == 32'h0) else $error("unmapped read not zero");
    a_upper_zero: assert property (rd |=> hrdata_out[31:16] == 16'h0)
        else $error("upper read bits set");
    a_status_width: assert property (rd && ix == `ITS_IDX_STATUS |=> hrdata_out[31:5] == 27'h0)
        else $error("reserved status bits set");
    a_tctrl_back: assert property (tk && hwrite_in && ix == `ITS_IDX_TCTRL ##1 !tk ##1 rd && ix == `ITS_IDX_TCTRL
        |=> hrdata_out == ($past(hwdata_in, 2) & 32'hff)) else $error("timer control readback");
    a_rise_hold0: assert property ($rose(timer_out[0]) |=> timer_out[0] [*3]) else $error("timer 0 high too short");
    a_rise_hold1: assert property ($rose(timer_out[1]) |=> timer_out[1] [*3]) else $error("timer 1 high too short");
    a_rise_hold2: assert property ($rose(timer_out[2]) |=> timer_out[2] [*3]) else $error("timer 2 high too short");
    c_status_read: cover property (rd && ix == `ITS_IDX_STATUS);
    c_timer2_rise: cover property ($rose(timer_out[2]));
    c_irq_rise: cover property ($rose(irq_out));
endmodule
bind its_timer_status its_timer_status_sva u_sva (.clk_in(clk_in), .resetn_in(resetn_in), .hsel_in(hsel_in),
    .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hwdata_in(hwdata_in),
    .hready_in(hready_in), .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
    .timer_out(timer_out), .irq_out(irq_out));

// ===== testbench/its_host_model.sv
// Host processor model: AHB-Lite master making single word register accesses
// Assumes one slave whose hreadyout is looped back as hready
`timescale 1ns/1ps
`include "its_map.vh"
module its_host_model (
    // Clock and slave answer
    input  logic        clk_in,
    input  logic        hready_in,
    input  logic [31:0] hrdata_in,
    // Master request
    output logic        hsel_out,
    output logic [31:0] haddr_out,
    output logic [1:0]  htrans_out,
    output logic        hwrite_out,
    output logic [2:0]  hsize_out,
    output logic [31:0] hwdata_out
);
    // Idle bus at time zero
    initial begin
        hsel_out = 1'b1;
        haddr_out = 32'h0;
        htrans_out = 2'h0;
        hwrite_out = 1'b0;
        hsize_out = 3'h2;
        hwdata_out = 32'h0;
    end
    // One transfer, entered just after a rising edge
    task xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
        logic [31:0] dm;
        dm = d;
        if (a[11:2] == `ITS_IDX_TCTRL) dm = d & 32'hfc;
        if (a[11:2] == `ITS_IDX_STATUS) dm = d & 32'h1f;
        haddr_out <= a;
        hwrite_out <= w;
        htrans_out <= 2'h2;
        hwdata_out <= ~hwdata_out;
        do @(posedge clk_in); while (hready_in !== 1'b1);
        htrans_out <= 2'h0;
        hwdata_out <= dm;
        do @(posedge clk_in); while (hready_in !== 1'b1);
        q = hrdata_in;
    endtask
endmodule

// ===== testbench/tb_interval_timer_irq_status.sv
// Bench: registers, error flags, timer periods, interrupt gating
// Assumes the host model drives the bus; this bench makes the pins
`timescale 1ns/1ps
`include "its_map.vh"
module tb_interval_timer_irq_status;
    logic clk_in = 1'b0, resetn_in = 1'b0, perr_n = 1'b1, serr_n = 1'b1, ext0 = 1'b0, ext1 = 1'b0;
    logic hsel, hwrite, hready, hresp, irq;
    logic [1:0] htrans;
    logic [2:0] hsize, tmr, tmr_d;
    logic [31:0] haddr, hwdata, hrdata, q;
    integer failures = 0, n_tests = 0, seed = 67601, r, i, k, n;
    localparam logic [31:0] A_ST = {20'h0, `ITS_IDX_STATUS, 2'b00}, A_TC = A_ST + 4, A_MSK = A_ST - 4;
    localparam logic [31:0] A_IRQ = A_ST - 8, A_R0 = {20'h0, `ITS_IDX_RELOAD0, 2'b00}, A_MODE = A_R0 + 12;
    logic [7:0] cfg [6] = '{8'h24, 8'h20, 8'h58, 8'h50, 8'h98, 8'hc8};
    integer bsel [6] = '{0, 0, 1, 1, 2, 2};
    integer unit [6] = '{8, 6, 8, 10, 8, 8};
    its_timer_status dut (.clk_in(clk_in), .resetn_in(resetn_in), .hsel_in(hsel), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hready),
        .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp), .ext_clock_in_0_in(ext0),
        .ext_clock_in_1_in(ext1), .perr_n_in(perr_n), .serr_n_in(serr_n), .timer_out(tmr), .irq_out(irq));
    its_host_model host (.clk_in(clk_in), .hready_in(hready), .hrdata_in(hrdata), .hsel_out(hsel),
        .haddr_out(haddr), .htrans_out(htrans), .hwrite_out(hwrite), .hsize_out(hsize), .hwdata_out(hwdata));
    // Clock, external timer clocks, previous timer outputs
    always #2 clk_in = ~clk_in;
    always begin repeat (3) @(posedge clk_in); ext0 <= ~ext0; end
    always begin repeat (5) @(posedge clk_in); ext1 <= ~ext1; end
    always @(posedge clk_in) tmr_d <= tmr;
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [31:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d, q);
    endtask
    task rd(input logic [31:0] a);
        host.xfer(1'b0, a, 32'h0, q);
    endtask
    // Error pin low for four cycles, then settle
    task pulse(input integer e);
        if (e == 0) perr_n <= 1'b0;
        else serr_n <= 1'b0;
        repeat (4) @(posedge clk_in);
        perr_n <= 1'b1;
        serr_n <= 1'b1;
        repeat (6) @(posedge clk_in);
    endtask
    // Cycles between two rising edges of one timer output
    task per(input integer b, output integer c);
        do begin @(posedge clk_in); #1; end while (!(tmr[b] && !tmr_d[b]));
        c = 0;
        do begin @(posedge clk_in); #1; c++; end while (!(tmr[b] && !tmr_d[b]));
    endtask
    task tally_and_finish;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Watchdog
    initial begin
        repeat (20000) @(posedge clk_in);
        failures++;
        tally_and_finish;
    end
    // Main sequence
    initial begin
        repeat (12) @(posedge clk_in);
        resetn_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        rd(A_ST); chk(q, 32'h0);
        rd(A_TC); chk(q, 32'h0);
        wr(32'h0, 32'hff); rd(32'h0); chk(q, 32'h0);
        wr(A_MODE, 32'h1); rd(A_MODE); chk(q, 32'h1);
        $display("test reset done");
        for (k = 0; k < 2; k++) begin
            pulse(k);
            n = 16 >> k;
            rd(A_ST); chk(q, n);
            chk({31'h0, irq}, 32'h0);
            wr(A_ST, 32'h1f ^ n); rd(A_ST); chk(q, n);
            wr(A_ST, n); rd(A_ST); chk(q, 32'h0);
        end
        $display("test error flags done");
        wr(A_MSK, 32'h10); wr(A_IRQ, 32'h10);
        rd(A_MSK); chk(q, 32'h10); rd(A_IRQ); chk(q, 32'h10);
        pulse(1); chk({31'h0, irq}, 32'h0);
        pulse(0); chk({31'h0, irq}, 32'h1);
        wr(A_IRQ, 32'h0); repeat (2) @(posedge clk_in); #1;
        chk({31'h0, irq}, 32'h0);
        wr(A_ST, 32'h1f);
        $display("test interrupt done");
        for (i = 0; i < 6; i++) begin
            r = 2 + {$random(seed)} % 4;
            wr(A_R0, r); wr(A_R0 + 4, r); wr(A_R0 + 8, r);
            wr(A_TC, cfg[i]); rd(A_TC); chk(q, cfg[i]);
            per(bsel[i], n);
            chk(n, unit[i] * r * (i == 5 ? r : 1));
            rd(A_ST); chk(q & (1 << bsel[i]), 1 << bsel[i]);
            wr(A_TC, 32'h0); wr(A_ST, 32'h1f);
            repeat (40) @(posedge clk_in);
            rd(A_ST); chk(q, 32'h0);
            $display("test timer config %0d done", i);
        end
        tally_and_finish;
    end
endmodule
